// ==== pipe_cfg_pkg.sv ====
// Constants and types for the second pipe's configuration and counters.
// Assumes byte addressing on the MMIO port and 32-bit register words.
package pipe_cfg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam int ADDR_W = 20;
    localparam logic [ADDR_W-1:0] CONF_OFS = 20'h71008;
    localparam logic [ADDR_W-1:0] FRAME_CNT_OFS = 20'h71040;
    localparam logic [ADDR_W-1:0] FLIP_CNT_OFS = 20'h71044;
    localparam logic [ADDR_W-1:0] FRAME_TIME_OFS = 20'h71048;
    localparam logic [ADDR_W-1:0] FLIP_TIME_OFS = 20'h7104C;

    ////////////////////////////////////////////////////////////////////////
    // Configuration field positions
    localparam int PS_BIT = 20;
    localparam int MSA_LO = 18;
    localparam int ASSOC_LO = 16;
    localparam int ROT_LO = 14;
    localparam int RANGE_BIT = 13;
    localparam int SPACE_LO = 11;
    localparam int BPC_LO = 5;
    localparam int DITH_BIT = 4;
    localparam int DTYPE_LO = 2;

    // Bits this block stores; all others read as zero
    localparam logic [31:0] CONF_WMASK = 32'h001FF8FC;
    localparam logic [31:0] CONF_RESET = 32'h00000000;
    localparam logic [31:0] COUNT_RESET = 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // Enumerations
    typedef enum logic [1:0] {
        ASSOC_NONE = 2'b00,
        ASSOC_PTP = 2'b01,
        ASSOC_PTI = 2'b10,
        ASSOC_RSVD = 2'b11
    } assoc_t;

    typedef enum logic [1:0] {
        SPACE_RGB = 2'b00,
        SPACE_YUV601 = 2'b01,
        SPACE_YUV709 = 2'b10,
        SPACE_RSVD = 2'b11
    } space_t;

endpackage

// ==== pipe_cnt_if.sv ====
// Interface between the config bank and its counter/timestamp unit.
// Assumes both ends run on the one display clock.
`timescale 1ns/10ps
interface pipe_cnt_if;
    logic frame_evt;        // Start of vertical blank pulse
    logic flip_evt;         // Primary surface flip pulse
    logic [31:0] stamp;     // Running timestamp
    logic [31:0] frame_cnt; // Frames seen
    logic [31:0] flip_cnt;  // Flips seen
    logic [31:0] frame_time; // Stamp at last vblank
    logic [31:0] flip_time; // Stamp at last flip

    modport bank (output frame_evt, flip_evt, stamp,
                  input frame_cnt, flip_cnt, frame_time, flip_time);
    modport unit (input frame_evt, flip_evt, stamp,
                  output frame_cnt, flip_cnt, frame_time, flip_time);
endinterface

// ==== pipe_counters.sv ====
// Frame and flip counters with their captured timestamps.
// Assumes event pulses are one cycle wide and on the display clock.
`timescale 1ns/10ps
module pipe_counters
    import pipe_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    pipe_cnt_if.unit cnt
);

    ////////////////////////////////////////////////////////////////////////
    logic [31:0] frame_cnt_q;
    logic [31:0] flip_cnt_q;
    logic [31:0] frame_time_q;
    logic [31:0] flip_time_q;

    // Counters wrap naturally at 32 bits; no write path exists at all
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frame_cnt_q <= COUNT_RESET;
            flip_cnt_q <= COUNT_RESET;
        end else begin
            if (cnt.frame_evt) begin
                frame_cnt_q <= frame_cnt_q + 32'h00000001; // see (R21)
            end
            if (cnt.flip_evt) begin
                flip_cnt_q <= flip_cnt_q + 32'h00000001; // see (R21)
            end
        end
    end

    // Stamps sampled on the event itself
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frame_time_q <= COUNT_RESET;
            flip_time_q <= COUNT_RESET;
        end else begin
            if (cnt.frame_evt) begin
                frame_time_q <= cnt.stamp; // see (R20)
            end
            if (cnt.flip_evt) begin
                flip_time_q <= cnt.stamp; // see (R19)
            end
        end
    end

    assign cnt.frame_cnt = frame_cnt_q;
    assign cnt.flip_cnt = flip_cnt_q;
    assign cnt.frame_time = frame_time_q;
    assign cnt.flip_time = flip_time_q;

endmodule

// ==== pipe_b_config.sv ====
// Second pipe configuration fields, rate-switch control and counters.
// Assumes all event inputs come from display logic on the same clock,
// and an MMIO port with one-cycle read and write strobes.
`timescale 1ns/10ps

// Summary of operation
// (R01) Power-save bit applies at next vblank
// (R02) Power-save acts only with association zero
// (R03) Power-save bit: 0 progressive, 1 saving
// (R04) Software gates clocks around power-save toggle
// (R05) Two bits pick MSA line one to four
// (R06) Refresh timing switches on MSA line
// (R07) Nonzero association needs interlace field zero
// (R08) No direct jump between association 01, 10
// (R09) Association zero: no rate change; 11 reserved
// (R10) Prog-to-prog: divider set two when low
// (R11) Prog-to-interlace: keep clock, halve M values
// (R12) Interlace by fitter if scaling, else fetch
// (R13) Rotation hint stored only, no hardware rotation
// (R14) Range bit: 0 full, 1 limited
// (R15) Colour space: RGB, YUV601, YUV709 to ports
// (R16) Depth codes give 8, 10, 6, 12 bits
// (R17) Depth change applies at next vblank
// (R18) Software enables dithering on depth mismatch
// (R19) Flip stamp captured on every surface flip
// (R20) Frame stamp captured at vblank start
// (R21) Read-only counters count frames and flips
module pipe_b_config
    import pipe_cfg_pkg::*;
#(
    parameter int M_W = 24
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] mmio_addr,
    input wire logic mmio_wr,
    input wire logic mmio_rd,
    input wire logic [31:0] mmio_wdata,
    output logic [31:0] mmio_rdata,
    output logic mmio_rvalid,
    input wire logic pipe_enabled,
    input wire logic vblank_start,
    input wire logic vblank_line_start,
    input wire logic [1:0] vblank_line_idx,
    input wire logic low_power_req,
    input wire logic scaling_en,
    input wire logic async_flip,
    input wire logic sync_flip,
    input wire logic surf_addr_wr,
    input wire logic [31:0] timestamp,
    input wire logic [M_W-1:0] data_m_in,
    input wire logic [M_W-1:0] link_m_in,
    output logic power_save_active,
    output logic msa_send,
    output logic rate_switch,
    output logic rate_low_active,
    output logic use_divider_set2,
    output logic [M_W-1:0] data_m_out,
    output logic [M_W-1:0] link_m_out,
    output logic fetch_interlaced,
    output logic fitter_interlace,
    output logic limited_range,
    output logic [1:0] color_space,
    output logic [3:0] bits_per_color,
    output logic dither_en,
    output logic [1:0] dither_type
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Depth code to bit count; reserved codes fall back to 8
    function automatic logic [3:0] bpc_decode(input logic [2:0] code);
        unique case (code)
            3'h0: bpc_decode = 4'h8;
            3'h1: bpc_decode = 4'hA;
            3'h2: bpc_decode = 4'h6;
            3'h3: bpc_decode = 4'hC;
            default: bpc_decode = 4'h8;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register state
    logic [31:0] conf_q;      // Written stage, used for readback
    logic [31:0] conf_d;
    logic [31:0] active_q;    // Stage that steers the pipe
    logic [31:0] active_d;
    logic rate_low_q;         // Low-power rate currently applied
    logic rate_low_d;
    logic msa_q;              // MSA line pulse
    logic switch_q;           // Rate switch pulse
    logic [M_W-1:0] data_m_q;
    logic [M_W-1:0] link_m_q;
    logic [31:0] rdata_q;
    logic rvalid_q;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    wire hit_conf = (mmio_addr == CONF_OFS);
    wire hit_frame_cnt = (mmio_addr == FRAME_CNT_OFS);
    wire hit_flip_cnt = (mmio_addr == FLIP_CNT_OFS);
    wire hit_frame_time = (mmio_addr == FRAME_TIME_OFS);
    wire hit_flip_time = (mmio_addr == FLIP_TIME_OFS);
    wire conf_wr = mmio_wr & hit_conf;

    // Only the stored fields take the write; counters ignore writes
    assign conf_d = conf_wr ? (mmio_wdata & CONF_WMASK) : conf_q;

    // Transfer at vblank start, or at once while the pipe is off
    wire update_pt = vblank_start | ~pipe_enabled;
    assign active_d = update_pt ? conf_d : active_q; // see (R01) (R17)

    ////////////////////////////////////////////////////////////////////////
    // Active field views
    wire act_ps = active_q[PS_BIT];
    wire [1:0] act_msa = active_q[MSA_LO +: 2];
    wire [1:0] act_assoc = active_q[ASSOC_LO +: 2];
    wire assoc_none = (act_assoc == ASSOC_NONE);
    wire assoc_ptp = (act_assoc == ASSOC_PTP);
    wire assoc_pti = (act_assoc == ASSOC_PTI);

    // MSA goes out on the chosen vblank line, 00 meaning the first
    wire msa_now = vblank_line_start & (vblank_line_idx == act_msa); // see (R05)

    // Rate state follows the request only on the MSA line in a dynamic
    // mode, and clears at once otherwise; reserved 11 behaves as none
    wire rate_mode = assoc_ptp | assoc_pti; // see (R09)
    assign rate_low_d = ~rate_mode ? 1'b0 :
                        msa_now ? low_power_req : rate_low_q; // see (R06)
    wire switch_now = msa_now & rate_mode & (low_power_req != rate_low_q);

    ////////////////////////////////////////////////////////////////////////
    // Configuration stages
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            conf_q <= CONF_RESET;
            active_q <= CONF_RESET;
        end else begin
            conf_q <= conf_d;
            active_q <= active_d;
        end
    end

    // Rate-switch state and line pulses
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rate_low_q <= 1'b0;
            msa_q <= 1'b0;
            switch_q <= 1'b0;
        end else begin
            rate_low_q <= rate_low_d;
            msa_q <= msa_now;
            switch_q <= switch_now; // see (R06)
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Divider values; halving keeps the pixel clock as it is
    wire pti_low = assoc_pti & rate_low_q;
    wire [M_W-1:0] data_m_sel = pti_low ? (data_m_in >> 1) : data_m_in;
    wire [M_W-1:0] link_m_sel = pti_low ? (link_m_in >> 1) : link_m_in;

    // Registered so the ports see one stable value per cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_m_q <= '0;
            link_m_q <= '0;
        end else begin
            data_m_q <= data_m_sel; // see (R11)
            link_m_q <= link_m_sel; // see (R11)
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter unit
    pipe_cnt_if cnt_bus ();

    assign cnt_bus.frame_evt = vblank_start; // see (R20) (R21)
    assign cnt_bus.flip_evt = async_flip | sync_flip | surf_addr_wr; // see (R19)
    assign cnt_bus.stamp = timestamp;

    pipe_counters u_counters (
        .clk(clk),
        .nrst(nrst),
        .cnt(cnt_bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read zero
    wire [31:0] rd_mux = hit_conf ? conf_q :
                         hit_frame_cnt ? cnt_bus.frame_cnt :
                         hit_flip_cnt ? cnt_bus.flip_cnt :
                         hit_frame_time ? cnt_bus.frame_time :
                         hit_flip_time ? cnt_bus.flip_time : 32'h00000000;

    // Read data held until the next read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= 32'h00000000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= mmio_rd;
            if (mmio_rd) begin
                rdata_q <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign mmio_rdata = rdata_q;
    assign mmio_rvalid = rvalid_q;

    // Saving mode counts only with association zero; 1 means saving
    assign power_save_active = act_ps & assoc_none; // see (R02) (R03)
    assign msa_send = msa_q; // see (R05)
    assign rate_switch = switch_q;
    assign rate_low_active = rate_low_q;

    // Second divider set only for the low-power side of prog-to-prog
    assign use_divider_set2 = assoc_ptp & rate_low_q; // see (R10)
    assign data_m_out = data_m_q;
    assign link_m_out = link_m_q;

    // Interlace source depends on whether the fitter is scaling
    assign fitter_interlace = pti_low & scaling_en; // see (R12)
    assign fetch_interlaced = pti_low & ~scaling_en; // see (R12)

    // Rotation bits are read back only; nothing here rotates, see (R13)
    assign limited_range = active_q[RANGE_BIT]; // see (R14)

    // Reserved colour space code is sent as RGB
    assign color_space = (active_q[SPACE_LO +: 2] == SPACE_RSVD) ?
                         SPACE_RGB : active_q[SPACE_LO +: 2]; // see (R15)
    assign bits_per_color = bpc_decode(active_q[BPC_LO +: 3]); // see (R16)
    assign dither_en = active_q[DITH_BIT];
    assign dither_type = active_q[DTYPE_LO +: 2];

endmodule

// ==== pipe_timing_model.sv ====
// Display timing model standing where the pipe's timing generator sits.
// Assumes one clock; frames of 24 cycles with four blank lines.
`timescale 1ns/10ps
module pipe_timing_model (
    input wire logic clk,
    input wire logic nrst,
    output logic vblank_start,
    output logic vblank_line_start,
    output logic [1:0] vblank_line_idx,
    output logic [31:0] timestamp
);
    logic [4:0] pos_q; // Position within the frame

    // Free running frame position and timestamp
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pos_q <= 5'h00;
            timestamp <= 32'h00000000;
        end else begin
            pos_q <= (pos_q == 5'h17) ? 5'h00 : pos_q + 5'h01;
            timestamp <= timestamp + 32'h00000003; // Step of 3 shows slips
        end
    end

    // Blank lines at positions 2, 4, 6 and 8
    assign vblank_start = (pos_q == 5'h00);
    assign vblank_line_start = !pos_q[0] && pos_q >= 5'h02 && pos_q <= 5'h08;
    assign vblank_line_idx = pos_q[2:1] - 2'h1;
endmodule

// ==== pipe_b_config_checker.sv ====
// Port checker for the second pipe configuration bank.
// Assumes binding to pipe_b_config on its single clock.
`timescale 1ns/10ps
module pipe_b_config_checker
    import pipe_cfg_pkg::*;
#(
    parameter int M_W = 24
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic mmio_rd,
    input wire logic mmio_rvalid,
    input wire logic pipe_enabled,
    input wire logic vblank_start,
    input wire logic vblank_line_start,
    input wire logic scaling_en,
    input wire logic [M_W-1:0] data_m_in,
    input wire logic power_save_active,
    input wire logic msa_send,
    input wire logic rate_switch,
    input wire logic rate_low_active,
    input wire logic use_divider_set2,
    input wire logic [M_W-1:0] data_m_out,
    input wire logic fetch_interlaced,
    input wire logic fitter_interlace,
    input wire logic [3:0] bits_per_color
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // Interlaced rate applied, by fitter or by fetch
    sequence pti_mode;
        fetch_interlaced || fitter_interlace;
    endsequence

    rd_answer_a: assert property (mmio_rd |=> mmio_rvalid)
        else $error("read not answered next cycle");
    rvalid_cause_a: assert property (mmio_rvalid |-> $past(mmio_rd))
        else $error("read valid without a read");
    msa_line_a: assert property (msa_send |-> $past(vblank_line_start))
        else $error("attribute sent off a blank line");
    switch_on_msa_a: assert property (rate_switch |-> msa_send)
        else $error("rate switch away from attribute line");
    ps_update_a: assert property ($changed(power_save_active) |->
        $past(vblank_start) || !$past(pipe_enabled))
        else $error("power save changed outside blank");
    depth_update_a: assert property ($changed(bits_per_color) |->
        $past(vblank_start) || !$past(pipe_enabled))
        else $error("depth changed outside blank");
    depth_legal_a: assert property (bits_per_color inside
        {4'h6, 4'h8, 4'hA, 4'hC})
        else $error("depth out of range");
    set2_low_a: assert property (use_divider_set2 |-> rate_low_active)
        else $error("second divider set at high rate");
    fetch_mode_a: assert property (fetch_interlaced |->
        rate_low_active && !scaling_en)
        else $error("interlaced fetch with scaling");
    fitter_mode_a: assert property (fitter_interlace |->
        rate_low_active && scaling_en)
        else $error("fitter interlace without scaling");
    halve_m_a: assert property (pti_mode |=>
        data_m_out == ($past(data_m_in) >> 1))
        else $error("data M not halved");
endmodule

bind pipe_b_config pipe_b_config_checker #(.M_W(M_W)) u_chk (.clk, .nrst,
    .mmio_rd, .mmio_rvalid, .pipe_enabled, .vblank_start, .vblank_line_start,
    .scaling_en, .data_m_in, .power_save_active, .msa_send, .rate_switch,
    .rate_low_active, .use_divider_set2, .data_m_out, .fetch_interlaced,
    .fitter_interlace, .bits_per_color);

// ==== tb_pipe_b_config.sv ====
// Self-checking bench for the second pipe configuration bank.
// Assumes the timing model supplies blanking and the timestamp.
`timescale 1ns/10ps
module tb_pipe_b_config
    import pipe_cfg_pkg::*;
;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, en = 1'b1;
    logic lpr = 1'b0, scl = 1'b0, af = 1'b0, sf = 1'b0, sw = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = '0, rdata, ts, seen, frm_ts, v;
    logic [23:0] dm = 24'h123456, lm = 24'h0ABCDE, dmo, lmo;
    logic rvalid, vbs, vls, ps, msa, rsw, rla, set2, fint, fit, lim, den;
    logic [1:0] idx, csp, dty;
    logic [3:0] bpc;
    int error_cnt = 0, compares = 0, cyc = 0, frames = 0;

    always #50 clk = ~clk;

    pipe_timing_model u_tim (.clk, .nrst, .vblank_start(vbs),
        .vblank_line_start(vls), .vblank_line_idx(idx), .timestamp(ts));

    pipe_b_config #(.M_W(24)) u_dut (.clk, .nrst, .mmio_addr(addr),
        .mmio_wr(wr), .mmio_rd(rd), .mmio_wdata(wdata), .mmio_rdata(rdata),
        .mmio_rvalid(rvalid), .pipe_enabled(en), .vblank_start(vbs),
        .vblank_line_start(vls), .vblank_line_idx(idx), .low_power_req(lpr),
        .scaling_en(scl), .async_flip(af), .sync_flip(sf),
        .surf_addr_wr(sw), .timestamp(ts), .data_m_in(dm), .link_m_in(lm),
        .power_save_active(ps), .msa_send(msa), .rate_switch(rsw),
        .rate_low_active(rla), .use_divider_set2(set2), .data_m_out(dmo),
        .link_m_out(lmo), .fetch_interlaced(fint), .fitter_interlace(fit),
        .limited_range(lim), .color_space(csp), .bits_per_color(bpc),
        .dither_en(den), .dither_type(dty));

    // Own record of frames and the stamp each one should capture
    always @(posedge clk) begin
        if (nrst && vbs) begin
            frames++;
            frm_ts = ts;
        end
    end

    // Hang guard; a full run needs about 610 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic test_done();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Bus cycles start one step after an edge and end the same way;
    // an idle edge follows so back-to-back calls never re-raise a strobe
    task automatic reg_wr(input logic [19:0] a, input logic [31:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk);
        #1 wr = 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic reg_rd(input logic [19:0] a, output logic [31:0] d);
        addr = a;
        rd = 1'b1;
        @(posedge clk);
        #1 rd = 1'b0;
        check(32'(rvalid), 32'h1);
        d = rdata;
        @(posedge clk);
        #1;
    endtask

    task automatic wait_vb();
        @(posedge clk iff vbs);
        #1;
    endtask

    // Reset values, plus an unmapped address reading zero
    task automatic t_reset();
        logic [19:0] ofs [6];
        ofs = '{CONF_OFS, FRAME_CNT_OFS, FLIP_CNT_OFS, FRAME_TIME_OFS,
            FLIP_TIME_OFS, 20'h71050};
        for (int i = 0; i < 6; i++) begin
            reg_rd(ofs[i], v);
            check(v, (i == 1) ? 32'(frames) : 32'h0);
        end
        check(32'(bpc), 32'h8);
    endtask

    // Stored bits, rotation hint readback, counter ignores writes
    task automatic t_mask();
        reg_wr(CONF_OFS, 32'hFF1FFFFF); // Interlace field zero
        reg_rd(CONF_OFS, v);
        check(v, CONF_WMASK);
        reg_wr(FRAME_CNT_OFS, 32'hFFFFFFFF);
        reg_rd(FRAME_CNT_OFS, v);
        check(v, 32'(frames));
        reg_wr(CONF_OFS, 32'h0);
        wait_vb();
    endtask

    // Depth codes apply only at the following blank
    task automatic t_depth();
        logic [3:0] exp [4];
        exp = '{4'h8, 4'hA, 4'h6, 4'hC};
        for (int c = 3; c >= 0; c--) begin
            wait_vb();
            // Dither on whenever depth is not the 8-bit buffer's
            reg_wr(CONF_OFS, (32'(c) << BPC_LO) |
                (32'(c != 0) << DITH_BIT));
            check(32'(bpc), (c == 3) ? 32'h8 : 32'(exp[c + 1]));
            wait_vb();
            check(32'(bpc), 32'(exp[c]));
        end
    endtask

    // Power save waits for blank and needs association zero
    task automatic t_power();
        wait_vb();
        reg_wr(CONF_OFS, 32'h00100000); // Gating stays off
        check(32'(ps), 32'h0);
        wait_vb();
        check(32'(ps), 32'h1);
        reg_wr(CONF_OFS, 32'h00110000);
        wait_vb();
        check(32'(ps), 32'h0);
        // A disabled pipe takes the write at once
        en = 1'b0;
        reg_wr(CONF_OFS, 32'h00100000);
        check(32'(ps), 32'h1);
        en = 1'b1;
    endtask

    // Range, colour space and dither fields; 11 space shows as RGB
    task automatic t_range();
        for (int i = 0; i < 4; i++) begin
            reg_wr(CONF_OFS, (32'(i) << SPACE_LO) | (32'(i & 1) << RANGE_BIT)
                | (32'(i) << DTYPE_LO) | (32'(i >> 1) << DITH_BIT));
            wait_vb();
            check(32'(csp), (i == 3) ? 32'h0 : 32'(i));
            check(32'(lim), 32'(i & 1));
            check({den, dty}, 32'((i >> 1) * 4 + i));
        end
    endtask

    // Wait for the attribute line; count edges from blank start
    task automatic msa_wait(input int f, input logic sw_exp);
        int n;
        n = 0;
        wait_vb();
        do begin
            @(posedge clk);
            #1 n++;
        end while (!msa && n < 30);
        check(32'(n), 32'(2 + 2 * f));
        check(32'(rsw), 32'(sw_exp));
        @(posedge clk);
        #1;
    endtask

    // Rate association modes, passing through none between them
    task automatic t_rate();
        lpr = 1'b1;
        for (int f = 0; f < 4; f++) begin
            reg_wr(CONF_OFS, (32'(f) << MSA_LO) | 32'h00010000);
            msa_wait(f, f == 0);
            check(32'(set2), 32'h1);
            check(32'(dmo), 32'(dm));
        end
        reg_wr(CONF_OFS, 32'h0);
        // Zero must become active, and the rate drops one edge later
        wait_vb();
        @(posedge clk);
        #1;
        check(32'(rla), 32'h0);
        for (int s = 0; s < 2; s++) begin
            scl = s[0];
            reg_wr(CONF_OFS, 32'h00020000);
            msa_wait(0, s == 0);
            check({dmo, 1'b0}, 32'({1'b0, dm}));
            check(32'(lmo), 32'(lm >> 1));
            check({fit, fint}, s ? 32'h2 : 32'h1);
        end
        lpr = 1'b0;
        msa_wait(0, 1'b1);
        check(32'(rla), 32'h0);
        check(32'(dmo), 32'(dm));
    endtask

    // Each flip kind counts once and captures the stamp
    task automatic t_flip();
        for (int k = 0; k < 3; k++) begin
            {af, sf, sw} = 3'b100 >> k;
            seen = ts;
            @(posedge clk);
            #1 {af, sf, sw} = 3'b000;
            reg_rd(FLIP_CNT_OFS, v);
            check(v, 32'(k + 1));
            reg_rd(FLIP_TIME_OFS, v);
            check(v, seen);
        end
        wait_vb();
        reg_rd(FRAME_CNT_OFS, v);
        check(v, 32'(frames));
        reg_rd(FRAME_TIME_OFS, v);
        check(v, frm_ts);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        #1 nrst = 1'b1;
        t_reset();
        t_mask();
        t_depth();
        t_power();
        t_range();
        t_rate();
        t_flip();
        test_done();
    end
endmodule
